// *** src/jtag_trace_defines.vh ***
// constants of the test and trace port: tap state indices, instruction codes,
// debug control fields and trace widths. assumes inclusion by bare name.
//
// Overview of operation
// - scan mode: selected register's serial bit goes out on tdo at falling tck.
// - tdo is left undriven whenever no scan or trace bit is being shifted out.
// - scan mode: tdi shifts into instruction or data register on rising tck.
// - trace mode: tdi low at rising tck ends trace, back to scan.
// - tms sampled on rising tck steps the tap state machine.
// - trst low resets debug logic asynchronously, apart from processor reset.
// - capture clock equals processor clock; undriven if control bit 0 or 15 zero.
// - three status lines report debug mode, pipeline stall and exception.
`ifndef JTAG_TRACE_DEFINES_VH
`define JTAG_TRACE_DEFINES_VH

// *****************************
// tap state bit positions
// *****************************
`define ST_TLR 0
`define ST_RTI 1
`define ST_SEL_DR 2
`define ST_CAP_DR 3
`define ST_SH_DR 4
`define ST_EX1_DR 5
`define ST_PAU_DR 6
`define ST_EX2_DR 7
`define ST_UPD_DR 8
`define ST_SEL_IR 9
`define ST_CAP_IR 10
`define ST_SH_IR 11
`define ST_EX1_IR 12
`define ST_PAU_IR 13
`define ST_EX2_IR 14
`define ST_UPD_IR 15

// *****************************
// instructions and data registers
// *****************************
`define IR_W 4
`define IR_IDCODE 4'h1
`define IR_DBG_CTRL 4'h2
`define IR_BYPASS 4'hF
`define IR_CAPTURE 4'h1
`define IDCODE_VAL 32'h1000_0001 // arbitrary value, names no maker or part
`define CTRL_W 16
`define CTRL_RESET 16'h0000
`define CTRL_CLK_EN_LO 0
`define CTRL_TRACE_EN 1
`define CTRL_CLK_EN_HI 15

// *****************************
// trace stream
// *****************************
`define PC_W 32
`define PC_CNT_W 6
`define PC_CNT_FULL 6'h20

`endif

// *** src/tap_state_machine.v ***
// sixteen-state test access port controller, advanced by a tck rising edge
// enable. assumes tms is already synchronised to clk and aligned with the edge.
`include "jtag_trace_defines.vh"

module tap_state_machine (
	input wire clk, // processor-side sampling clock
	input wire trst_n, // asynchronous debug reset, active low
	input wire tck_rise, // one-cycle pulse per rising tck
	input wire tms, // synchronised mode select
	output reg [15:0] state_r // one-hot tap state
);
	localparam [15:0] S_TLR = 16'h0001;
	localparam [15:0] S_RTI = 16'h0002;
	localparam [15:0] S_SEL_DR = 16'h0004;
	localparam [15:0] S_CAP_DR = 16'h0008;
	localparam [15:0] S_SH_DR = 16'h0010;
	localparam [15:0] S_EX1_DR = 16'h0020;
	localparam [15:0] S_PAU_DR = 16'h0040;
	localparam [15:0] S_EX2_DR = 16'h0080;
	localparam [15:0] S_UPD_DR = 16'h0100;
	localparam [15:0] S_SEL_IR = 16'h0200;
	localparam [15:0] S_CAP_IR = 16'h0400;
	localparam [15:0] S_SH_IR = 16'h0800;
	localparam [15:0] S_EX1_IR = 16'h1000;
	localparam [15:0] S_PAU_IR = 16'h2000;
	localparam [15:0] S_EX2_IR = 16'h4000;
	localparam [15:0] S_UPD_IR = 16'h8000;

	reg [15:0] state_nxt;

	// tms high walks every state to test-logic-reset in at most five edges
	always @* begin
		case (state_r)
			S_TLR: state_nxt = tms ? S_TLR : S_RTI;
			S_RTI: state_nxt = tms ? S_SEL_DR : S_RTI;
			S_SEL_DR: state_nxt = tms ? S_SEL_IR : S_CAP_DR;
			S_CAP_DR: state_nxt = tms ? S_EX1_DR : S_SH_DR;
			S_SH_DR: state_nxt = tms ? S_EX1_DR : S_SH_DR;
			S_EX1_DR: state_nxt = tms ? S_UPD_DR : S_PAU_DR;
			S_PAU_DR: state_nxt = tms ? S_EX2_DR : S_PAU_DR;
			S_EX2_DR: state_nxt = tms ? S_UPD_DR : S_SH_DR;
			S_UPD_DR: state_nxt = tms ? S_SEL_DR : S_RTI;
			S_SEL_IR: state_nxt = tms ? S_TLR : S_CAP_IR;
			S_CAP_IR: state_nxt = tms ? S_EX1_IR : S_SH_IR;
			S_SH_IR: state_nxt = tms ? S_EX1_IR : S_SH_IR;
			S_EX1_IR: state_nxt = tms ? S_UPD_IR : S_PAU_IR;
			S_PAU_IR: state_nxt = tms ? S_EX2_IR : S_PAU_IR;
			S_EX2_IR: state_nxt = tms ? S_UPD_IR : S_SH_IR;
			S_UPD_IR: state_nxt = tms ? S_SEL_DR : S_RTI;
			default: state_nxt = S_TLR;
		endcase
	end

	always @(posedge clk or negedge trst_n) begin
		if (!trst_n) begin
			state_r <= S_TLR;
		end else if (tck_rise) begin
			state_r <= state_nxt;
		end
	end
endmodule

// *** src/jtag_trace_debug_port.v ***
// test and debug port: scan access through a tap, a debug control register
// and a serial program counter trace on tdo.
// assumes tck, tms, tdi and trst_n come from pins; processor signals are on ref_clk.
`include "jtag_trace_defines.vh"

module jtag_trace_debug_port (
	input wire ref_clk, // 50 MHz clock
	input wire reset_n, // processor-side reset, active low
	input wire tck, // test clock pin
	input wire tms, // test mode select pin
	input wire tdi, // test data input pin
	input wire trst_n, // test reset pin, active low
	input wire pc_load, // pulse: non-sequential pc to trace
	input wire [31:0] pc_value, // pc value with pc_load
	input wire cpu_debug_mode, // processor is in debug mode
	input wire cpu_stall, // processor pipeline stalled
	input wire cpu_exception, // processor took an exception
	output reg tdo, // test data / trace output
	output reg tdo_oe, // tdo driven when high
	output reg trace_capture_clock, // processor clock copy for trace capture
	output reg trace_capture_clock_oe, // capture clock driven when high
	output reg [2:0] cpu_status_lines, // debug, stall, exception
	output reg trace_active // trace mode is on
);
	// *****************************
	// pin synchronisers
	// *****************************
	wire [2:0] pin_raw;
	reg [2:0] pin_meta_r;
	reg [2:0] pin_sync_r;
	reg tck_prev_r;

	assign pin_raw = {tdi, tms, tck};
	// reset to tck's idle low so no false edge follows a reset
	// limitation: a reset_n pulse while tck is high yields one false rise

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : sync_g
			always @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					pin_meta_r[g] <= 1'b0;
					pin_sync_r[g] <= 1'b0;
				end else begin
					pin_meta_r[g] <= pin_raw[g];
					pin_sync_r[g] <= pin_meta_r[g];
				end
			end
		end
	endgenerate

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tck_prev_r <= 1'b0;
		end else begin
			tck_prev_r <= pin_sync_r[0];
		end
	end

	wire tck_s = pin_sync_r[0];
	wire tms_s = pin_sync_r[1];
	wire tdi_s = pin_sync_r[2];
	wire tck_rise = tck_s & ~tck_prev_r;
	wire tck_fall = ~tck_s & tck_prev_r;

	// *****************************
	// tap controller
	// *****************************
	wire [15:0] tap_state;
	// tap lags the pin by about three ref_clk cycles; tms and tdi must stand around each tck edge

	tap_state_machine u_tap (
		.clk(ref_clk),
		.trst_n(trst_n),
		.tck_rise(tck_rise),
		.tms(tms_s),
		.state_r(tap_state)
	);

	// *****************************
	// instruction and data registers
	// *****************************
	reg [`IR_W-1:0] ir_r;
	reg [`IR_W-1:0] ir_shift_r;
	reg [31:0] dr_shift_r;
	reg [31:0] dr_shift_nxt;
	reg [`CTRL_W-1:0] ctrl_r;

	// unknown instructions fall to a one-bit bypass that captures zero
	// shift toward bit 0, new bit enters at the top of the selected length
	function [31:0] dr_shifted;
		input [`IR_W-1:0] ir;
		input [31:0] sh;
		input bit_in;
		begin
			case (ir)
				`IR_IDCODE: dr_shifted = {bit_in, sh[31:1]};
				`IR_DBG_CTRL: dr_shifted = {16'h0000, bit_in, sh[15:1]};
				default: dr_shifted = {31'h0000_0000, bit_in};
			endcase
		end
	endfunction

	always @* begin
		dr_shift_nxt = dr_shift_r;
		if (tap_state[`ST_CAP_DR]) begin
			case (ir_r)
				`IR_IDCODE: dr_shift_nxt = `IDCODE_VAL;
				`IR_DBG_CTRL: dr_shift_nxt = {16'h0000, ctrl_r};
				default: dr_shift_nxt = 32'h0000_0000;
			endcase
		end else if (tap_state[`ST_SH_DR]) begin
			dr_shift_nxt = dr_shifted(ir_r, dr_shift_r, tdi_s);
		end
	end

	// registers hang off trst_n only so a processor reset leaves debug state alone
	always @(posedge ref_clk or negedge trst_n) begin
		if (!trst_n) begin
			ir_r <= `IR_IDCODE;
			ir_shift_r <= {`IR_W{1'b0}};
			dr_shift_r <= 32'h0000_0000;
			ctrl_r <= `CTRL_RESET;
		end else if (tck_rise) begin
			dr_shift_r <= dr_shift_nxt;
			if (tap_state[`ST_TLR]) begin
				ir_r <= `IR_IDCODE;
				ctrl_r <= `CTRL_RESET;
			end
			if (tap_state[`ST_CAP_IR]) begin
				ir_shift_r <= `IR_CAPTURE;
			end else if (tap_state[`ST_SH_IR]) begin
				ir_shift_r <= {tdi_s, ir_shift_r[`IR_W-1:1]};
			end
			if (tap_state[`ST_UPD_IR]) begin
				ir_r <= ir_shift_r;
			end
			// a control write in the same edge wins over the trace exit
			if (tap_state[`ST_UPD_DR] && ir_r == `IR_DBG_CTRL) begin
				ctrl_r <= dr_shift_r[`CTRL_W-1:0];
			end else if (ctrl_r[`CTRL_TRACE_EN] && !tdi_s) begin
				ctrl_r[`CTRL_TRACE_EN] <= 1'b0;
			end
		end
	end

	// *****************************
	// trace stream
	// *****************************
	reg [`PC_W-1:0] pc_shift_r;
	reg [`PC_CNT_W-1:0] pc_cnt_r;
	reg pc_pend_r;
	reg [`PC_W-1:0] pc_hold_r;

	wire trace_on = ctrl_r[`CTRL_TRACE_EN];
	// capture clock falls after a high phase: tdo moves there, one bit per processor clock
	wire cpu_en = trace_capture_clock;

	always @(posedge ref_clk or negedge trst_n) begin
		if (!trst_n) begin
			pc_shift_r <= {`PC_W{1'b0}};
			pc_cnt_r <= {`PC_CNT_W{1'b0}};
			pc_pend_r <= 1'b0;
			pc_hold_r <= {`PC_W{1'b0}};
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
			trace_active <= 1'b0;
		end else begin
			trace_active <= trace_on;
			if (!trace_on) begin
				pc_cnt_r <= {`PC_CNT_W{1'b0}};
				pc_pend_r <= 1'b0;
				if (tck_fall) begin
					tdo <= tap_state[`ST_SH_IR] ? ir_shift_r[0] : dr_shift_r[0];
					tdo_oe <= tap_state[`ST_SH_IR] | tap_state[`ST_SH_DR];
				end else if (trace_active) begin
					// trace has just ended: release tdo instead of leaving a stale trace bit driven
					tdo_oe <= 1'b0;
				end
			end else begin
				// a new pc while one is pending replaces it; the stream shows the latest
				if (pc_load) begin
					pc_pend_r <= 1'b1;
					pc_hold_r <= pc_value;
				end
				if (cpu_en) begin
					if (pc_cnt_r != {`PC_CNT_W{1'b0}}) begin
						tdo <= pc_shift_r[0];
						tdo_oe <= 1'b1;
						pc_shift_r <= {1'b0, pc_shift_r[`PC_W-1:1]};
						pc_cnt_r <= pc_cnt_r - 1'b1;
					end else begin
						tdo_oe <= 1'b0;
						// no load while a pc_load lands, so the pending set never meets its clear
						if (pc_pend_r && !pc_load) begin
							pc_shift_r <= pc_hold_r;
							pc_cnt_r <= `PC_CNT_FULL;
							pc_pend_r <= 1'b0;
						end
					end
				end
			end
		end
	end

	// *****************************
	// capture clock and status lines
	// *****************************
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			trace_capture_clock <= 1'b0;
			trace_capture_clock_oe <= 1'b0;
			cpu_status_lines <= 3'h0;
		end else begin
			// processor clock taken as ref_clk halved; keeps running through a trst pulse
			trace_capture_clock <= ~trace_capture_clock;
			trace_capture_clock_oe <= ctrl_r[`CTRL_CLK_EN_LO] & ctrl_r[`CTRL_CLK_EN_HI];
			cpu_status_lines <= {cpu_exception, cpu_stall, cpu_debug_mode};
		end
	end
endmodule

// *** bench/jtag_port_properties.sv ***
// concurrent checks on the test and trace port pins.
// assumes binding to the port's top module, ref_clk domain.
module jtag_port_properties (
	input wire ref_clk, // clock
	input wire reset_n, // cpu reset
	input wire trst_n, // test reset
	input wire tck, // test clock
	input wire tms, // mode select
	input wire tdi, // data in
	input wire cpu_debug_mode, // status in
	input wire cpu_stall, // status in
	input wire cpu_exception, // status in
	input wire tdo, // data out
	input wire tdo_oe, // out enable
	input wire trace_capture_clock, // capture clock
	input wire [2:0] cpu_status_lines, // status out
	input wire trace_active // trace on
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [2:0] tms_run_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n || !trst_n);
	// saturating run of tck rises seen with tms high
	always @(posedge ref_clk or negedge trst_n) begin
		if (!trst_n)
			tms_run_r <= 3'h0;
		else if ($rose(tck))
			tms_run_r <= !tms ? 3'h0 : (tms_run_r == 3'h5 ? 3'h5 : tms_run_r + 3'h1);
	end
	chk_status_copy: assert property (disable iff (!reset_n)
		cpu_status_lines == $past({cpu_exception, cpu_stall, cpu_debug_mode})) else $error("status mismatch");
	chk_clock_toggle: assert property (disable iff (!reset_n)
		$past(reset_n) |-> trace_capture_clock != $past(trace_capture_clock)) else $error("no toggle");
	chk_scan_on_fall: assert property (
		!trace_active && $past(!trace_active, 3) && $changed(tdo) |-> !$past(tck, 2)) else $error("tdo off fall");
	chk_oe_on_fall: assert property (
		!trace_active && $rose(tdo_oe) |-> !$past(tck, 2)) else $error("oe off fall");
	chk_trace_hold: assert property (
		trace_active && tdo_oe && $past(tdo_oe) && trace_capture_clock |-> $stable(tdo)) else $error("bit moved");
	chk_trace_exit: assert property (
		trace_active && $rose(tck) && !tdi |-> ##[1:12] !trace_active) else $error("no trace exit");
	chk_trst_clears: assert property (disable iff (!reset_n)
		!trst_n |=> !tdo_oe && !trace_active) else $error("trst ignored");
	chk_five_tms_idle: assert property (
		tms_run_r == 3'h5 && !trace_active |-> !tdo_oe) else $error("tdo driven in reset");
	cover property ($rose(trace_active));
	cover property (tdo_oe && !trace_active);
	cover property ($fell(trace_active));
endmodule

bind jtag_trace_debug_port jtag_port_properties chk (.ref_clk, .reset_n, .trst_n, .tck, .tms, .tdi,
	.cpu_debug_mode, .cpu_stall, .cpu_exception, .tdo, .tdo_oe, .trace_capture_clock,
	.cpu_status_lines, .trace_active);

// *** bench/jtag_probe.sv ***
// debug probe model: drives the test pins, reads tdo.
// assumes 50 MHz ref_clk; tck period is eight ref_clk cycles, low when idle.
module jtag_probe (
	input wire ref_clk, // clock
	input wire tdo, // data out
	input wire tdo_oe, // out enable
	output logic tck, // test clock
	output logic tms, // mode select
	output logic tdi, // data in
	output logic trst_n // test reset
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b0;
	end
	// call just after an edge; returns what the previous fall launched
	task step(input logic m, input logic d, output logic o, output logic oe);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge ref_clk);
		tck <= 1'b1;
		repeat (4) @(posedge ref_clk);
		o = tdo_oe ? tdo : ~tdo; // released pin reads as the inverse, not a stale bit
		oe = tdo_oe;
		tck <= 1'b0;
	endtask
	task set_trst(input logic v);
		trst_n <= v;
	endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench: probe on the test pins, cpu side driven here.
// assumes the probe holds trst_n low until released.
`include "jtag_trace_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, reset_n = 1'b0, pc_load = 1'b0, dbg = 1'b0, stall = 1'b0, exc = 1'b0;
	logic [31:0] pc_value = 32'h0, got;
	logic o, oe;
	wire tck, tms, tdi, trst_n, tdo, tdo_oe, cap_clk, cap_oe, trace_on;
	wire [2:0] status;
	int err_total = 0, check_count = 0, cyc = 0;
	jtag_trace_debug_port DUT (.ref_clk, .reset_n, .tck, .tms, .tdi, .trst_n, .pc_load, .pc_value,
		.cpu_debug_mode(dbg), .cpu_stall(stall), .cpu_exception(exc), .tdo, .tdo_oe,
		.trace_capture_clock(cap_clk), .trace_capture_clock_oe(cap_oe), .cpu_status_lines(status),
		.trace_active(trace_on));
	jtag_probe probe (.ref_clk, .tdo, .tdo_oe, .tck, .tms, .tdi, .trst_n);
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			results();
		end
	end
	task results;
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// tms path, lsb first, tdi held high
	task walk(input logic [7:0] p, input int n);
		for (int i = 0; i < n; i++)
			probe.step(p[i], 1'b1, o, oe);
	endtask
	task shift(input int n, input logic [31:0] din);
		logic all;
		all = 1'b1;
		got = 32'h0;
		for (int i = 0; i < n; i++) begin
			probe.step(i == n - 1, din[i], o, oe);
			got[i] = o;
			all &= oe;
		end
		chk(all, 1'b1);
	endtask
	task t_idcode;
		walk(8'h02, 4);
		shift(32, 32'hFFFF_FFFF);
		chk(got, `IDCODE_VAL);
		walk(8'h01, 2);
		chk(oe, 1'b0);
	endtask
	task t_trace_on;
		walk(8'h03, 4);
		shift(`IR_W, `IR_DBG_CTRL);
		chk(got[3:0], `IR_CAPTURE);
		walk(8'h03, 4);
		shift(`CTRL_W, 32'h8003);
		chk(got[15:0], `CTRL_RESET);
		walk(8'h01, 2);
		repeat (4) @(posedge ref_clk);
		chk(trace_on, 1'b1);
		chk(cap_oe, 1'b1);
	endtask
	task t_stream;
		int n;
		n = 0;
		{exc, stall, dbg} <= 3'b011;
		pc_value <= 32'hA5C3_0F96;
		pc_load <= 1'b1;
		@(posedge ref_clk);
		pc_load <= 1'b0;
		for (int i = 0; i < 300 && n < 32; i++) begin
			@(negedge ref_clk);
			if (tdo_oe && cap_clk) begin
				got[n] = tdo;
				n++;
			end
		end
		@(posedge ref_clk);
		chk(got, 32'hA5C3_0F96);
		chk(status, 3'b011);
		{exc, stall, dbg} <= 3'b100;
		repeat (2) @(posedge ref_clk);
		chk(status, 3'b100);
		{exc, stall, dbg} <= 3'b000;
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		chk(trace_on, 1'b1);
		probe.step(1'b0, 1'b0, o, oe);
		repeat (8) @(posedge ref_clk);
		chk(trace_on, 1'b0);
		chk(tdo_oe, 1'b0);
	endtask
	task t_tlr;
		walk(8'h1F, 5);
		repeat (4) @(posedge ref_clk);
		chk(cap_oe, 1'b0);
		t_idcode();
		walk(8'h02, 4);
		probe.step(1'b0, 1'b1, o, oe);
		repeat (6) @(posedge ref_clk);
		chk(tdo_oe, 1'b1);
		probe.set_trst(1'b0);
		repeat (3) @(posedge ref_clk);
		chk(tdo_oe, 1'b0);
		probe.set_trst(1'b1);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		probe.set_trst(1'b1);
		repeat (3) @(posedge ref_clk);
		t_idcode();
		t_trace_on();
		t_stream();
		t_tlr();
		results();
	end
endmodule
